/* File: hw/ptlv_cfg.svh */
// offsets, field positions, reset values and fixed codes of the template builder
// assumes: included by the package, the top module, the checker and the bench
`ifndef PTLV_CFG_SVH
`define PTLV_CFG_SVH
// register word addresses
`define PTLV_REG_CTRL      6'h00
`define PTLV_REG_CHAR      6'h01
`define PTLV_REG_COUNT     6'h02
`define PTLV_REG_STATUS    6'h03
`define PTLV_REG_POW_BASE  6'h10
`define PTLV_REG_CLK_BASE  6'h20
// control fields
`define PTLV_CTRL_KIND_LSB 0
`define PTLV_CTRL_CHAR_EN  2
`define PTLV_CTRL_START    8
// count fields
`define PTLV_CNT_POW_LSB   0
`define PTLV_CNT_CLK_LSB   4
// tags and lengths of the template
`define PTLV_TAG_TEMPLATE  8'hA5
`define PTLV_TAG_CHAR      8'h80
`define PTLV_TAG_POWER     8'h81
`define PTLV_TAG_MINCLK    8'h82
`define PTLV_LEN_CHAR      8'h01
`define PTLV_LEN_POWER     8'h03
`define PTLV_LEN_MINCLK    8'h01
`define PTLV_SIZE_CHAR     8'h03
`define PTLV_SIZE_POWER    8'h05
`define PTLV_SIZE_MINCLK   8'h03
// characteristics byte bits
`define PTLV_CHAR_STOP_OK  0
`define PTLV_CHAR_PREF_HI  2
`define PTLV_CHAR_PREF_LO  3
`define PTLV_CHAR_MASK     8'h7D
// measurement class and consumption masks
`define PTLV_CLASS_MASK    8'h07
`define PTLV_MA_MASK       8'h3F
// frequency coding, 0.1 MHz steps
`define PTLV_FREQ_MIN      8'h0A
`define PTLV_FREQ_NONE     8'hFF
// reset values
`define PTLV_CHAR_RST      8'h00
`endif

/* File: hw/ptlv_pkg.sv */
// types shared by the template builder
// assumes: the cfg header is on the include path
`include "ptlv_cfg.svh"
package ptlv_pkg;
  // kind of file the selection response describes
  typedef enum logic [1:0] {
    PTLV_ROOT = 2'h0,
    PTLV_DIR  = 2'h1,
    PTLV_ADF  = 2'h2,
    PTLV_EF   = 2'h3
  } ptlv_kind_t;
  // emitter phase, one-hot
  typedef enum logic [4:0] {
    PTLV_IDLE = 5'h01,
    PTLV_HEAD = 5'h02,
    PTLV_CHAR = 5'h04,
    PTLV_POW  = 5'h08,
    PTLV_CLK  = 5'h10
  } ptlv_state_t;
endpackage

/* File: hw/ptlv_builder.sv */
// proprietary-information template builder of the card side
// assumes: register port and byte sink run on clk; sink takes a byte when
// tx_valid and tx_ready are both high
//
// Chosen here: the register offsets and the strobed register port.
`timescale 1ns/10ps
`include "ptlv_cfg.svh"

module ptlv_builder #(
  parameter int N_POW = 4,  // power consumption slots
  parameter int N_CLK = 4   // minimum clock slots
) (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic [5:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata,
  output logic      [7:0]        tx_data,
  output logic                   tx_valid,
  input  wire logic              tx_ready,
  output logic                   busy,
  output ptlv_pkg::ptlv_kind_t   kind
);
  import ptlv_pkg::*;

  localparam int PW = $clog2(N_POW + 1);  // width of the power count
  localparam int CW = $clog2(N_CLK + 1);  // width of the clock count

  // software-written configuration
  ptlv_kind_t    kind_q;                  // file kind of the response
  logic          char_en_q;               // characteristics for non-root files
  logic [7:0]    char_q;                  // characteristics byte, cleaned
  logic [PW-1:0] npow_q;                  // power objects to send
  logic [CW-1:0] nclk_q;                  // minimum clock objects to send
  logic [7:0]    pow_class_q [N_POW];     // measurement class per slot
  logic [7:0]    pow_ma_q    [N_POW];     // consumption per slot
  logic [7:0]    pow_freq_q  [N_POW];     // reference frequency per slot
  logic [7:0]    clk_min_q   [N_CLK];     // minimum clock per slot
  // emitter state
  ptlv_state_t   st_q;                    // current phase
  logic [2:0]    sub_q;                   // byte inside the object
  logic [3:0]    idx_q;                   // object index inside a group
  logic [7:0]    sent_q;                  // bytes sent in last template
  logic [7:0]    tx_data_q;               // output byte
  logic          tx_valid_q;              // output byte valid
  logic [31:0]   rdata_q;                 // read answer
  // decoded
  logic          inc_char;                // characteristics object included
  logic          inc_pow;                 // power group included
  logic          inc_clk;                 // clock group included
  logic [7:0]    tmpl_len;                // template value length
  logic [7:0]    cur_byte;                // byte of the current position
  logic          take;                    // output register may load
  logic          last_sub;                // last byte of current object
  logic          last_idx;                // last object of current group
  logic          start;                   // start command
  logic          cfg_wr;                  // configuration write allowed

  assign start  = reg_wr && (reg_addr == `PTLV_REG_CTRL) && reg_wdata[`PTLV_CTRL_START] && (st_q == PTLV_IDLE);
  assign cfg_wr = reg_wr && (st_q == PTLV_IDLE);
  assign take   = (st_q != PTLV_IDLE) && (!tx_valid_q || tx_ready);

  // clean the characteristics byte before storing it
  function automatic logic [7:0] clean_char(input logic [7:0] v);
    logic [7:0] r;
    r = v & `PTLV_CHAR_MASK;
    // both preferences set is reserved: drop both, the safe reading
    if (r[`PTLV_CHAR_PREF_HI] && r[`PTLV_CHAR_PREF_LO]) begin
      r[`PTLV_CHAR_PREF_HI] = 1'b0;
      r[`PTLV_CHAR_PREF_LO] = 1'b0;
    end
    return r;
  endfunction

  // clamp a frequency code into 0A..FF
  function automatic logic [7:0] clamp_freq(input logic [7:0] v);
    return (v < `PTLV_FREQ_MIN) ? `PTLV_FREQ_MIN : v;
  endfunction

  // which objects the template carries
  always_comb begin
    inc_char = (kind_q == PTLV_ROOT) || char_en_q;
    inc_pow  = (kind_q == PTLV_ADF) && (npow_q != '0);
    inc_clk  = (kind_q == PTLV_ADF) && (nclk_q != '0);
    tmpl_len = (inc_char ? `PTLV_SIZE_CHAR : 8'h00)
             + (inc_pow ? 8'(`PTLV_SIZE_POWER * npow_q) : 8'h00)
             + (inc_clk ? 8'(`PTLV_SIZE_MINCLK * nclk_q) : 8'h00);
  end

  // byte at the current position of the stream
  always_comb begin
    cur_byte = 8'h00;
    last_sub = 1'b0;
    last_idx = 1'b1;
    unique case (st_q)
      PTLV_IDLE: begin
        cur_byte = 8'h00;
      end
      PTLV_HEAD: begin
        cur_byte = (sub_q == 3'h0) ? `PTLV_TAG_TEMPLATE : tmpl_len;
        last_sub = (sub_q == 3'h1);
      end
      PTLV_CHAR: begin
        unique case (sub_q)
          3'h0:    cur_byte = `PTLV_TAG_CHAR;
          3'h1:    cur_byte = `PTLV_LEN_CHAR;
          default: cur_byte = char_q;
        endcase
        last_sub = (sub_q == 3'h2);
      end
      PTLV_POW: begin
        unique case (sub_q)
          3'h0:    cur_byte = `PTLV_TAG_POWER;
          3'h1:    cur_byte = `PTLV_LEN_POWER;
          3'h2:    cur_byte = pow_class_q[idx_q[$clog2(N_POW)-1:0]];
          3'h3:    cur_byte = pow_ma_q[idx_q[$clog2(N_POW)-1:0]];
          default: cur_byte = pow_freq_q[idx_q[$clog2(N_POW)-1:0]];
        endcase
        last_sub = (sub_q == 3'h4);
        last_idx = (idx_q == 4'(npow_q - 1'b1));
      end
      PTLV_CLK: begin
        unique case (sub_q)
          3'h0:    cur_byte = `PTLV_TAG_MINCLK;
          3'h1:    cur_byte = `PTLV_LEN_MINCLK;
          default: cur_byte = clk_min_q[idx_q[$clog2(N_CLK)-1:0]];
        endcase
        last_sub = (sub_q == 3'h2);
        last_idx = (idx_q == 4'(nclk_q - 1'b1));
      end
    endcase
  end

  // phase that follows a finished group; same tags stay together
  function automatic ptlv_state_t next_phase(input ptlv_state_t s, input logic ic, input logic ip,
                                             input logic ik);
    ptlv_state_t n;
    n = PTLV_IDLE;
    if (s == PTLV_HEAD && ic) begin
      n = PTLV_CHAR;
    end else if ((s == PTLV_HEAD || s == PTLV_CHAR) && ip) begin
      n = PTLV_POW;
    end else if (s != PTLV_CLK && ik) begin
      n = PTLV_CLK;
    end
    return n;
  endfunction

  // emitter sequencing
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_q  <= PTLV_IDLE;
      sub_q <= 3'h0;
      idx_q <= 4'h0;
    end else if (start) begin
      st_q  <= PTLV_HEAD;
      sub_q <= 3'h0;
      idx_q <= 4'h0;
    end else if (take) begin
      if (!last_sub) begin
        sub_q <= sub_q + 3'h1;
      end else if (!last_idx) begin
        // next object of the same tag
        sub_q <= 3'h0;
        idx_q <= idx_q + 4'h1;
      end else begin
        sub_q <= 3'h0;
        idx_q <= 4'h0;
        st_q  <= next_phase(st_q, inc_char, inc_pow, inc_clk);
      end
    end
  end

  // output byte register with back-pressure from the sink
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_data_q  <= 8'h00;
      tx_valid_q <= 1'b0;
    end else if (take) begin
      tx_data_q  <= cur_byte;
      tx_valid_q <= 1'b1;
    end else if (tx_ready) begin
      tx_valid_q <= 1'b0;
    end
  end

  // byte counter of the template in flight
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sent_q <= 8'h00;
    end else if (start) begin
      sent_q <= 8'h00;
    end else if (take) begin
      sent_q <= sent_q + 8'h01;
    end
  end

  // control and scalar configuration, ignored while a template is sent
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      kind_q    <= PTLV_ROOT;
      char_en_q <= 1'b0;
      char_q    <= `PTLV_CHAR_RST;
      npow_q    <= '0;
      nclk_q    <= '0;
    end else if (cfg_wr) begin
      if (reg_addr == `PTLV_REG_CTRL) begin
        kind_q    <= ptlv_kind_t'(reg_wdata[`PTLV_CTRL_KIND_LSB +: 2]);
        char_en_q <= reg_wdata[`PTLV_CTRL_CHAR_EN];
      end
      if (reg_addr == `PTLV_REG_CHAR) begin
        char_q <= clean_char(reg_wdata[7:0]);
      end
      if (reg_addr == `PTLV_REG_COUNT) begin
        // counts above the slot number are clamped
        npow_q <= (reg_wdata[`PTLV_CNT_POW_LSB +: 4] > 4'(N_POW)) ? PW'(N_POW)
                                                                    : PW'(reg_wdata[`PTLV_CNT_POW_LSB +: 4]);
        nclk_q <= (reg_wdata[`PTLV_CNT_CLK_LSB +: 4] > 4'(N_CLK)) ? CW'(N_CLK)
                                                                    : CW'(reg_wdata[`PTLV_CNT_CLK_LSB +: 4]);
      end
    end
  end

  // power consumption slots
  for (genvar i = 0; i < N_POW; i++) begin : g_pow
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        pow_class_q[i] <= 8'h00;
        pow_ma_q[i]    <= 8'h00;
        pow_freq_q[i]  <= `PTLV_FREQ_NONE;
      end else if (cfg_wr && reg_addr == (`PTLV_REG_POW_BASE + 6'(i))) begin
        pow_class_q[i] <= reg_wdata[7:0] & `PTLV_CLASS_MASK;
        pow_ma_q[i]    <= reg_wdata[15:8] & `PTLV_MA_MASK;
        pow_freq_q[i]  <= clamp_freq(reg_wdata[23:16]);
      end
    end
  end

  // minimum clock slots
  for (genvar j = 0; j < N_CLK; j++) begin : g_clk
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        clk_min_q[j] <= `PTLV_FREQ_NONE;
      end else if (cfg_wr && reg_addr == (`PTLV_REG_CLK_BASE + 6'(j))) begin
        clk_min_q[j] <= clamp_freq(reg_wdata[7:0]);
      end
    end
  end

  // read answer, one cycle after the strobe, zero elsewhere
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= 32'h0000_0000;
      if (reg_rd) begin
        if (reg_addr == `PTLV_REG_CTRL) begin
          rdata_q[1:0]                 <= kind_q;
          rdata_q[`PTLV_CTRL_CHAR_EN]  <= char_en_q;
        end else if (reg_addr == `PTLV_REG_CHAR) begin
          rdata_q[7:0] <= char_q;
        end else if (reg_addr == `PTLV_REG_COUNT) begin
          rdata_q[`PTLV_CNT_POW_LSB +: PW] <= npow_q;
          rdata_q[`PTLV_CNT_CLK_LSB +: CW] <= nclk_q;
        end else if (reg_addr == `PTLV_REG_STATUS) begin
          rdata_q[0]    <= (st_q != PTLV_IDLE);
          rdata_q[15:8] <= sent_q;
          rdata_q[23:16] <= tmpl_len;
        end else if (reg_addr >= `PTLV_REG_POW_BASE && reg_addr < (`PTLV_REG_POW_BASE + 6'(N_POW))) begin
          rdata_q[23:0] <= {pow_freq_q[reg_addr[$clog2(N_POW)-1:0]], pow_ma_q[reg_addr[$clog2(N_POW)-1:0]],
                            pow_class_q[reg_addr[$clog2(N_POW)-1:0]]};
        end else if (reg_addr >= `PTLV_REG_CLK_BASE && reg_addr < (`PTLV_REG_CLK_BASE + 6'(N_CLK))) begin
          rdata_q[7:0] <= clk_min_q[reg_addr[$clog2(N_CLK)-1:0]];
        end
      end
    end
  end

  // busy flag register for the outside
  logic busy_q;  // template being sent
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= start || (st_q != PTLV_IDLE && !(take && last_sub && last_idx &&
                next_phase(st_q, inc_char, inc_pow, inc_clk) == PTLV_IDLE));
    end
  end

  assign reg_rdata = rdata_q;
  assign tx_data   = tx_data_q;
  assign tx_valid  = tx_valid_q;
  assign busy      = busy_q;
  assign kind      = kind_q;
endmodule

/* File: tb/ptlv_builder_assertions.sv */
// port checker of the template builder
// assumes: bound to ptlv_builder, one clock clk, synchronous reset sys_rst
`timescale 1ns/10ps
`include "ptlv_cfg.svh"
module ptlv_builder_assertions
  import ptlv_pkg::*;
#(
  parameter int N_POW = 4,  // power slots of the bound design
  parameter int N_CLK = 4   // clock slots of the bound design
) (
  input wire logic                 clk,
  input wire logic                 sys_rst,
  input wire logic [5:0]           reg_addr,
  input wire logic [31:0]          reg_wdata,
  input wire logic                 reg_wr,
  input wire logic                 reg_rd,
  input wire logic [31:0]          reg_rdata,
  input wire logic [7:0]           tx_data,
  input wire logic                 tx_valid,
  input wire logic                 tx_ready,
  input wire logic                 busy,
  input wire ptlv_pkg::ptlv_kind_t kind
);
  logic       start;  // start write that the builder will honour
  logic [7:0] pos_q;  // bytes taken since start
  logic [7:0] len_q;  // announced template length
  assign start = reg_wr && reg_addr == `PTLV_REG_CTRL && reg_wdata[`PTLV_CTRL_START] && !busy && !tx_valid;
  // count bytes handed over in this template
  always_ff @(posedge clk) begin
    if (sys_rst || start) begin
      pos_q <= 8'h00;
    end else if (tx_valid && tx_ready) begin
      pos_q <= pos_q + 8'h01;
    end
  end
  // keep the length byte once it passes
  always_ff @(posedge clk) begin
    if (sys_rst || start) begin
      len_q <= 8'hFF;
    end else if (tx_valid && tx_ready && pos_q == 8'h01) begin
      len_q <= tx_data;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_start;
    start;
  endsequence
  sequence s_head;
    tx_valid && tx_data == `PTLV_TAG_TEMPLATE;
  endsequence
  AST_FIRST_BYTE: assert property (s_start |-> ##[1:2] s_head)
    else $error("template tag late or wrong");
  AST_HEAD: assert property (tx_valid && pos_q == 8'h00 |-> s_head)
    else $error("first byte is not the template tag");
  AST_STAND: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("byte dropped or changed while stalled");
  AST_ROOT_CHAR: assert property (kind == PTLV_ROOT && tx_valid && pos_q == 8'h02 |-> tx_data == `PTLV_TAG_CHAR)
    else $error("root template lacks characteristics object");
  AST_CHAR_LEN: assert property (kind == PTLV_ROOT && tx_valid && pos_q == 8'h03 |-> tx_data == `PTLV_LEN_CHAR)
    else $error("characteristics length wrong");
  AST_CHAR_RSV: assert property (kind == PTLV_ROOT && tx_valid && pos_q == 8'h04
    |-> (tx_data & 8'h82) == 8'h00)
    else $error("reserved characteristics bits set");
  AST_NON_ADF: assert property (kind != PTLV_ADF && tx_valid && pos_q >= 8'h02
    |-> tx_data != `PTLV_TAG_POWER && tx_data != `PTLV_TAG_MINCLK)
    else $error("application object outside application directory");
  AST_LENGTH: assert property (tx_valid && pos_q >= 8'h02 |-> pos_q < len_q + 8'h02)
    else $error("template runs past its length");
  AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
  AST_BUSY: assert property (s_start |=> busy)
    else $error("busy missing after start");
endmodule
bind ptlv_builder ptlv_builder_assertions #(.N_POW(N_POW), .N_CLK(N_CLK)) i_chk (
  .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_data(tx_data), .tx_valid(tx_valid),
  .tx_ready(tx_ready), .busy(busy), .kind(kind));

/* File: tb/ptlv_sink.sv */
// terminal side: takes template bytes and walks the nested objects
// assumes: same clock as the builder; a byte passes when tx_valid and tx_ready
`timescale 1ns/10ps
module ptlv_sink #(
  parameter logic [7:0] USE_CLASS = 8'h01,  // supply class the terminal runs at
  parameter int         RESCALE   = 1,      // factor from another class to the one in use
  parameter logic [7:0] MA_LIMIT  = 8'h3C   // current budget of the class in use
) (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       clr,       // forget the captured template
  input  wire logic       stall,     // accept only one cycle in three
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  output logic [7:0]      got [0:63],
  output int              n_got,
  output logic [1:0]      stop_mode, // 0 never, 1 high only, 2 low only, 3 either
  output int              n_pow,     // usable consumption figures
  output int              n_clk      // minimum clock figures given
);
  logic [1:0] ph_q;  // pacing phase
  // acceptance pacing
  always_ff @(posedge clk) begin
    ph_q     <= (sys_rst || ph_q == 2'h2) ? 2'h0 : ph_q + 2'h1;
    tx_ready <= !sys_rst && (!stall || ph_q == 2'h2);
  end
  // byte capture
  always_ff @(posedge clk) begin
    if (sys_rst || clr) begin
      n_got <= 0;
    end else if (tx_valid && tx_ready) begin
      got[n_got] <= tx_data;
      n_got      <= n_got + 1;
    end
  end
  // walk objects; repeated tags are all taken in order
  always_comb begin
    int i;
    logic [7:0] ma;
    i         = 2;
    ma        = 8'h00;
    stop_mode = 2'h0;
    n_pow     = 0;
    n_clk     = 0;
    while (i + 1 < n_got) begin
      case (got[i])
        8'h80: stop_mode = got[i+2][0] ? 2'h3 : got[i+2][3:2];
        8'h81: begin
          // figure measured at another class is brought to the class in use
          ma = (got[i+2] == USE_CLASS) ? got[i+3] : 8'(got[i+3] * RESCALE);
          if (got[i+3] != 8'h00 && got[i+3] <= 8'h3C && ma <= MA_LIMIT) n_pow++;
        end
        8'h82: if (got[i+2] != 8'hFF) n_clk++;
        default: ;
      endcase
      i = i + 2 + got[i+1];
    end
  end
endmodule

/* File: tb/ptlv_builder_tb.sv */
// self-checking bench of the template builder
// assumes: builder, sink model and checker compiled before it
`timescale 1ns/10ps
`include "ptlv_cfg.svh"
module ptlv_builder_tb;
  import ptlv_pkg::*;
  logic       clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, clr = 1'b0, stall = 1'b0;
  logic [5:0] reg_addr = 6'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic [7:0] tx_data, got [0:63], exp_q [$];
  logic       tx_valid, tx_ready, busy;
  logic [1:0] stop_mode;
  ptlv_kind_t kind;
  int         n_got, n_pow, n_clk, n_errors = 0, checks_done = 0, cycles = 0;
  logic [7:0] chars [4] = '{8'h35, 8'h24, 8'h48, 8'h00};
  logic [1:0] modes [4] = '{2'h3, 2'h1, 2'h2, 2'h0};
  ptlv_builder #(.N_POW(4), .N_CLK(4)) i_dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .busy(busy), .kind(kind));
  ptlv_sink i_sink (.clk(clk), .sys_rst(sys_rst), .clr(clr), .stall(stall), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .got(got), .n_got(n_got), .stop_mode(stop_mode),
    .n_pow(n_pow), .n_clk(n_clk));
  // clock
  initial begin
    forever #12.5 clk = ~clk;
  end
  // hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    if (n_errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(reg_rdata, e);
    @(posedge clk);
  endtask
  // append one nested object to the expected stream
  task automatic obj(input logic [7:0] t, input logic [7:0] l, input logic [23:0] v);
    exp_q.push_back(t);
    exp_q.push_back(l);
    for (int i = 0; i < l; i++) exp_q.push_back(v[8*i +: 8]);
  endtask
  // start a template, optionally poke a register mid-way, compare the stream
  task automatic run(input logic [31:0] ctrl, input logic poke);
    int t;
    exp_q.push_front(8'(exp_q.size()));
    exp_q.push_front(8'hA5);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    wr(`PTLV_REG_CTRL, ctrl | 32'h100);
    chk(busy, 1'b1);
    if (poke) wr(`PTLV_REG_CHAR, 32'h7D);
    t = 0;
    while ((busy !== 1'b0 || tx_valid !== 1'b0) && t < 500) begin
      @(posedge clk);
      t++;
    end
    chk(32'(t >= 500), 32'h0);
    chk(n_got, exp_q.size());
    foreach (exp_q[i]) chk(got[i], exp_q[i]);
    exp_q.delete();
  endtask
  initial begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rd(`PTLV_REG_CHAR, 32'h0);
    rd(`PTLV_REG_POW_BASE, 32'h00FF0000);
    rd(`PTLV_REG_CLK_BASE, 32'h000000FF);
    rd(6'h3F, 32'h0);
    wr(`PTLV_REG_CHAR, 32'hFF);
    rd(`PTLV_REG_CHAR, 32'h71);
    wr(`PTLV_REG_COUNT, 32'hFF);
    rd(`PTLV_REG_COUNT, 32'h44);
    wr(`PTLV_REG_POW_BASE, 32'h000A3C01);
    wr(`PTLV_REG_POW_BASE + 6'h01, 32'h00FFFF0D);
    rd(`PTLV_REG_POW_BASE + 6'h01, 32'h00FF3F05);
    wr(`PTLV_REG_POW_BASE + 6'h02, 32'h00FF0000);
    wr(`PTLV_REG_CLK_BASE, 32'h05);
    rd(`PTLV_REG_CLK_BASE, 32'h0A);
    wr(`PTLV_REG_CLK_BASE + 6'h01, 32'h0B);
    wr(`PTLV_REG_CLK_BASE + 6'h02, 32'hFF);
    wr(`PTLV_REG_COUNT, 32'h33);
    // root file: only the characteristics object, for each stop policy
    foreach (chars[i]) begin
      wr(`PTLV_REG_CHAR, {24'h0, chars[i]});
      obj(8'h80, 8'h01, {16'h0, chars[i]});
      run(32'h0, 1'b0);
      chk(stop_mode, modes[i]);
    end
    chk(kind, PTLV_ROOT);
    // directory with characteristics asked for, elementary file without
    obj(8'h80, 8'h01, 24'h0);
    run(32'h5, 1'b0);
    run(32'h3, 1'b0);
    // application directory, stalling sink, write dropped mid-template
    stall <= 1'b1;
    obj(8'h81, 8'h03, 24'h0A3C01);
    obj(8'h81, 8'h03, 24'hFF3F05);
    obj(8'h81, 8'h03, 24'hFF0000);
    obj(8'h82, 8'h01, 24'h0A);
    obj(8'h82, 8'h01, 24'h0B);
    obj(8'h82, 8'h01, 24'hFF);
    run(32'h2, 1'b1);
    chk(n_pow, 1);
    chk(n_clk, 2);
    chk(kind, PTLV_ADF);
    rd(`PTLV_REG_CHAR, 32'h0);
    rd(`PTLV_REG_STATUS, 32'h00181A00);
    give_verdict();
  end
endmodule
